// file: rtl/sbfm_chan_filter.sv
// Purpose: Synchronise and deglitch one blocking request channel
// Assumes: Channel high means ON (normal operation)
// Notes: OFF must persist longer than the glitch time to be accepted
`include "sbfm_params.svh"
module sbfm_chan_filter #(
  parameter int GLITCH_CYC = `SBFM_GLITCH_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic chan_in,
  output logic chan_on_q
);
  logic meta_q;
  logic sync_q;
  logic [17:0] off_cnt_q;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= chan_in;
      sync_q <= meta_q;
    end

  // ----------------------------------------
  // Off filter: ON is taken at once, OFF after the glitch time
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      off_cnt_q <= 18'h0;
      chan_on_q <= 1'b0;
    end
    else if (sync_q)
    begin
      off_cnt_q <= 18'h0;
      chan_on_q <= 1'b1;
    end
    else if (off_cnt_q >= 18'(GLITCH_CYC - 1))
      chan_on_q <= 1'b0;
    else
      off_cnt_q <= off_cnt_q + 18'h1;
endmodule : sbfm_chan_filter

// file: rtl/sbfm_monitor.sv
// Purpose: Feedback monitor for two-channel hardwired current blocking
// Assumes: Inputs asynchronous, synchronised per channel; high on a channel means ON (normal)
// Notes: Powers up blocked; no software registers
`include "sbfm_params.svh"
module sbfm_monitor #(
  parameter int SKEW_CYC = `SBFM_SKEW_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic block_request_a,
  input wire logic block_request_b,
  output logic feedback_monitor_out,
  output logic motor_power_enable,
  output sbfm_pkg::sbfm_code_t display_code,
  output logic [1:0] safety_input_status_monitor,
  output logic input_timing_alarm
);
  import sbfm_pkg::*;

  logic [1:0] chan_raw;
  logic [1:0] chan_on;
  logic a_on;
  logic b_on;
  logic both_on;
  logic both_off;
  logic one_off;
  logic [31:0] skew_cnt_q;
  sbfm_state_t state_q;
  sbfm_state_t state_d;

  // ----------------------------------------
  // Decoding shared by several outputs
  // ----------------------------------------
  function automatic logic is_alarm(input sbfm_state_t s);
    is_alarm = (s == SBFM_ALARM);
  endfunction : is_alarm

  function automatic logic may_run(input sbfm_state_t s, input logic both);
    may_run = both && (s == SBFM_RUN);
  endfunction : may_run

  // Alarm outranks the blocked code so a stuck channel stays visible
  function automatic sbfm_code_t code_of(input sbfm_state_t s, input logic off2);
    if (is_alarm(s))
      code_of = `SBFM_CODE_ALARM;
    else if (off2)
      code_of = `SBFM_CODE_BLOCKED;
    else
      code_of = `SBFM_CODE_RUN;
  endfunction : code_of

  // ----------------------------------------
  // Channel conditioning
  // ----------------------------------------
  assign chan_raw = {block_request_b, block_request_a};

  genvar gi;
  for (gi = 0; gi < 2; gi++)
  begin : g_chan
    sbfm_chan_filter u_filt (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .chan_in(chan_raw[gi]),
      .chan_on_q(chan_on[gi])
    );
  end

  assign a_on = chan_on[0];
  assign b_on = chan_on[1];
  assign both_on = a_on && b_on;
  assign both_off = !a_on && !b_on;
  assign one_off = a_on ^ b_on;

  // ----------------------------------------
  // Skew timer for a single channel off
  // ----------------------------------------
  // Saturates so a long single-off cannot wrap back under the limit
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      skew_cnt_q <= 32'h0;
    end
    else if (!one_off)
    begin
      skew_cnt_q <= 32'h0;
    end
    else if (skew_cnt_q < 32'(SKEW_CYC))
    begin
      skew_cnt_q <= skew_cnt_q + 32'h1;
    end

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  // Any channel dropping leaves RUN at once
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SBFM_RUN:
      begin
        if (both_off)
          state_d = SBFM_BLOCKED;
        else if (one_off)
          state_d = SBFM_ONE_OFF;
      end
      SBFM_ONE_OFF:
      begin
        if (both_off)
          state_d = SBFM_BLOCKED;
        else if (!one_off)
          state_d = SBFM_RUN;
        else if (skew_cnt_q >= 32'(SKEW_CYC))
          state_d = SBFM_ALARM;
      end
      SBFM_BLOCKED:
      begin
        if (both_on)
          state_d = SBFM_RUN;
        else if (one_off)
          state_d = SBFM_ONE_OFF;
      end
      SBFM_ALARM:
      begin
        // Alarm is latched until resetn is asserted
        state_d = SBFM_ALARM;
      end
      default:
      begin
        state_d = SBFM_BLOCKED;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Powers up blocked, so an open jumper never lets current flow
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      state_q <= SBFM_BLOCKED;
    end
    else
    begin
      state_q <= state_d;
    end

  // ----------------------------------------
  // Feedback and motor power
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      feedback_monitor_out <= 1'b0;
    end
    else
    begin
      feedback_monitor_out <= both_off;
    end

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      motor_power_enable <= 1'b0;
    end
    else
    begin
      motor_power_enable <= may_run(state_d, both_on);
    end

  // ----------------------------------------
  // Display and alarm
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      display_code <= `SBFM_CODE_BLOCKED;
    end
    else
    begin
      display_code <= code_of(state_d, both_off);
    end

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      input_timing_alarm <= 1'b0;
    end
    else
    begin
      input_timing_alarm <= is_alarm(state_d);
    end

  // ----------------------------------------
  // Status monitor
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      safety_input_status_monitor <= 2'h0;
    end
    else
    begin
      safety_input_status_monitor <= {b_on, a_on};
    end
endmodule : sbfm_monitor

// file: rtl/sbfm_params.svh
// Purpose: Constants for the safety block feedback monitor
// Assumes: 200 MHz system clock
// Notes: Times in their own unit, counts derived from the clock rate
`ifndef SBFM_PARAMS_SVH
`define SBFM_PARAMS_SVH
`define SBFM_CLK_MHZ 200
`define SBFM_GLITCH_US 500
`define SBFM_GLITCH_CYC (`SBFM_GLITCH_US * `SBFM_CLK_MHZ + 1)
`define SBFM_FB_DELAY_MS 20
`define SBFM_FB_DELAY_CYC (`SBFM_FB_DELAY_MS * 1000 * `SBFM_CLK_MHZ)
`define SBFM_SKEW_S 10
`define SBFM_SKEW_CYC (`SBFM_SKEW_S * 1000000 * `SBFM_CLK_MHZ)
`define SBFM_CODE_RUN 2'h0
`define SBFM_CODE_BLOCKED 2'h1
`define SBFM_CODE_ALARM 2'h2
`endif

// file: rtl/sbfm_pkg.sv
// Purpose: Types for the safety block feedback monitor
// Assumes: Constants live in sbfm_params.svh
// Notes: Gray coded states along the usual path
package sbfm_pkg;
  typedef enum logic [1:0]
  {
    SBFM_RUN = 2'h0,
    SBFM_ONE_OFF = 2'h1,
    SBFM_BLOCKED = 2'h3,
    SBFM_ALARM = 2'h2
  } sbfm_state_t;
  typedef logic [1:0] sbfm_code_t;
endpackage : sbfm_pkg

// file: sim/sbfm_properties.sv
// Purpose: Port checker for sbfm_monitor
// Assumes: Sees top ports only
// Notes: Bound below
`include "sbfm_params.svh"
module sbfm_chk #(
  parameter int SKEW_CYC = 1000
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic block_request_a,
  input wire logic block_request_b,
  input wire logic feedback_monitor_out,
  input wire logic motor_power_enable,
  input wire sbfm_pkg::sbfm_code_t display_code,
  input wire logic [1:0] safety_input_status_monitor,
  input wire logic input_timing_alarm
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic fb = feedback_monitor_out;
  wire logic al = input_timing_alarm;
  wire logic [1:0] st = safety_input_status_monitor;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_fb; fb |-> st == 2'h0; endproperty
  a_fb: assert property (p_fb) else $error("fb early");
  property p_on; |st |-> !fb; endproperty
  a_on: assert property (p_on) else $error("fb on");
  property p_bc; fb && !al |-> display_code == `SBFM_CODE_BLOCKED; endproperty
  a_bc: assert property (p_bc) else $error("code");
  property p_mp; motor_power_enable |-> st == 2'h3 && !al; endproperty
  a_mp: assert property (p_mp) else $error("power");
  property p_al; al |=> al && display_code == `SBFM_CODE_ALARM; endproperty
  a_al: assert property (p_al) else $error("alarm");
  property p_gl; $fell(st[1]) && $past(resetn) |-> !$past(block_request_b, 8); endproperty
  a_gl: assert property (p_gl) else $error("glitch");
  property p_sy; $rose(st[0]) |-> $past(block_request_a, 3); endproperty
  a_sy: assert property (p_sy) else $error("sync");
  property p_rt; (block_request_a && block_request_b) [*8] |-> st == 2'h3; endproperty
  a_rt: assert property (p_rt) else $error("slow");
  c_fb: cover property ($rose(fb));
  c_al: cover property ($rose(al));
  c_mp: cover property ($rose(motor_power_enable));
endmodule : sbfm_chk
bind sbfm_monitor sbfm_chk #(.SKEW_CYC(SKEW_CYC)) u_chk (.*);

// file: sim/sbfm_safety_unit.sv
// Purpose: Guard driven safety unit model
// Assumes: Channel high = ON
// Notes: brk cuts channel B wiring
module sbfm_safety_unit (
  input wire logic sys_clk,
  input wire logic guard_open,
  input wire logic stuck_a,
  input wire logic brk,
  input wire logic feedback,
  output logic ch_a,
  output logic ch_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_q = 1'b1;
  logic b_q = 1'b1;
  always @(posedge sys_clk)
  begin
    if (guard_open)
    begin
      a_q <= stuck_a;
      b_q <= 1'b0;
    end
    else if (feedback)
    begin
      a_q <= 1'b1;
      b_q <= 1'b1;
    end
  end
  assign ch_a = a_q;
  assign ch_b = b_q & ~brk;
endmodule : sbfm_safety_unit

// file: sim/tb_top.sv
// Purpose: Bench for sbfm_monitor
// Assumes: 200 MHz clock
// Notes: Off filter is full length
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic guard_open = 1'b0;
  logic stuck_a = 1'b0;
  logic brk = 1'b0;
  logic ch_a, ch_b, fb, mpe, alm;
  sbfm_pkg::sbfm_code_t disp;
  logic [1:0] st;
  int n_fail = 0;
  int n_checks = 0;
  sbfm_safety_unit u_su (.sys_clk(sys_clk), .guard_open(guard_open), .stuck_a(stuck_a),
    .brk(brk), .feedback(fb), .ch_a(ch_a), .ch_b(ch_b));
  sbfm_monitor #(.SKEW_CYC(1000)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .block_request_a(ch_a), .block_request_b(ch_b), .feedback_monitor_out(fb),
    .motor_power_enable(mpe), .display_code(disp), .safety_input_status_monitor(st),
    .input_timing_alarm(alm));
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic t_open();
    int n;
    guard_open = 1'b1;
    for (n = 0; n < 4000000 && fb !== 1'b1; n++)
      cyc(1);
    chk("delay", 4'h1, {3'h0, n > 99999 && n < 4000000});
    chk("off", 4'h4, {mpe, fb, st});
    chk("code", 4'h1, {2'h0, disp});
    guard_open = 1'b0;
    cyc(10);
    chk("rerun", 4'hB, {mpe, fb, st});
    chk("rcode", 4'h0, {2'h0, disp});
  endtask : t_open
  task automatic t_stuck();
    stuck_a = 1'b1;
    guard_open = 1'b1;
    cyc(102000);
    chk("one", 4'h1, {mpe, fb, st});
    chk("alarm", 4'hA, {alm, 1'b0, disp});
    guard_open = 1'b0;
    cyc(10);
    chk("refuse", 4'h1, {mpe, fb, st});
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(10);
    chk("clear", 4'h0, {3'h0, alm});
  endtask : t_stuck
  initial
  begin
    cyc(20);
    chk("pwrup", 4'h1, {2'h0, disp});
    resetn = 1'b1;
    cyc(10);
    chk("run", 4'hB, {mpe, fb, st});
    brk = 1'b1;
    cyc(100000);
    brk = 1'b0;
    cyc(10);
    chk("glitch", 4'hB, {mpe, fb, st});
    t_open();
    t_stuck();
    summarize();
  end
  initial
  begin
    #2500000;
    n_fail++;
    summarize();
  end
endmodule : tb_top
